// file: inc/tmc_pkg.sv
// constants of the timer 3 control block: sfr addresses, control bit positions, reset values, dividers
// assumes an 8-bit sfr bus clocked by the core clock
package tmc_pkg;
   localparam logic [7:0] ADDR_CONTROL = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

   localparam int BIT_HIGH_OVF = 7;
   localparam int BIT_LOW_OVF = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_SRC_MSB = 1;
   localparam int BIT_SRC_LSB = 0;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   localparam int SYS_DIV = 12;
   localparam int OSC_DIV = 8;

   typedef enum logic [1:0] {
      SRC_SYS12 = 2'b00,
      SRC_OSC8 = 2'b01,
      SRC_SYS12_ALT = 2'b10,
      SRC_CMP = 2'b11
   } tmc_src_t;
endpackage : tmc_pkg

// file: inc/tmc_src_if.sv
// tick carrier between the source selector and the timer core
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface tmc_src_if;
   tmc_pkg::tmc_src_t src_sel;
   logic ext_tick;
   logic cap_tick;
   modport src (input src_sel, output ext_tick, output cap_tick);
   modport core (output src_sel, input ext_tick, input cap_tick);
endinterface : tmc_src_if

// file: rtl/tmc_clk_src.sv
// external clock and capture trigger generator for timer 3
// assumes asynchronous comparator and oscillator pins and one core clock
`timescale 1ns/1ps
module tmc_clk_src #(
   parameter int SYS_DIV = tmc_pkg::SYS_DIV,
   parameter int OSC_DIV = tmc_pkg::OSC_DIV
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_comparator,
   input wire logic i_ext_osc,
   tmc_src_if.src src
);
   logic [1:0] cmp_sync;
   logic [1:0] osc_sync;
   logic cmp_prev;
   logic osc_prev;
   logic [3:0] sys_cnt;
   logic [3:0] osc_cnt;
   logic cmp_rise;
   logic osc_rise;
   logic sys12_tick;
   logic osc8_tick;

   // two-stage synchronisers, then edge detect on the second stage
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cmp_sync <= 2'b00;
         osc_sync <= 2'b00;
         cmp_prev <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         cmp_sync <= {cmp_sync[0], i_comparator};
         osc_sync <= {osc_sync[0], i_ext_osc};
         cmp_prev <= cmp_sync[1];
         osc_prev <= osc_sync[1];
      end
   end

   assign cmp_rise = cmp_sync[1] & ~cmp_prev;
   assign osc_rise = osc_sync[1] & ~osc_prev;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         sys_cnt <= 4'h0;
      end else if (sys_cnt == 4'(SYS_DIV - 1)) begin
         sys_cnt <= 4'h0;
      end else begin
         sys_cnt <= sys_cnt + 4'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         osc_cnt <= 4'h0;
      end else if (osc_rise) begin
         osc_cnt <= (osc_cnt == 4'(OSC_DIV - 1)) ? 4'h0 : osc_cnt + 4'h1;
      end
   end

   assign sys12_tick = (sys_cnt == 4'(SYS_DIV - 1));
   assign osc8_tick = osc_rise & (osc_cnt == 4'(OSC_DIV - 1));

   always_comb begin
      case (src.src_sel)
         tmc_pkg::SRC_SYS12: src.ext_tick = sys12_tick;
         tmc_pkg::SRC_OSC8: src.ext_tick = osc8_tick;
         tmc_pkg::SRC_SYS12_ALT: src.ext_tick = sys12_tick;
         tmc_pkg::SRC_CMP: src.ext_tick = cmp_rise;
         default: src.ext_tick = sys12_tick;
      endcase
   end

   // trigger is the oscillator/8 for codes 01 and 11, comparator edge otherwise
   assign src.cap_tick = src.src_sel[0] ? osc8_tick : cmp_rise;

   a_sys12_period: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      sys12_tick |=> !sys12_tick [*8])
      else $error("divide-by-12 tick repeated too soon");
endmodule : tmc_clk_src

// file: rtl/tmc_timer3.sv
// timer 3 control logic: control sfr, 16-bit or split counters, reload, capture, overflow flags
// assumes a single-cycle sfr write/read strobe on the core clock and asynchronous source pins
`timescale 1ns/1ps
module tmc_timer3 (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_high_byte_clock_select,
   input wire logic i_low_byte_clock_select,
   input wire logic i_timer_irq_enable,
   input wire logic i_comparator,
   input wire logic i_ext_osc,
   output logic o_timer_irq
);
   logic [7:0] timer3_control;
   logic [7:0] reload_low_byte;
   logic [7:0] reload_high_byte;
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] next_count_low;
   logic [7:0] next_count_high;
   logic high_ovf_set;
   logic low_ovf_set;
   logic tick_low;
   logic tick_high;
   logic split_select;
   logic run_control;
   logic capture_event;
   logic wr_ctrl;
   logic wr_cnt_low;
   logic wr_cnt_high;

   tmc_src_if src_bus ();

   tmc_clk_src u_clk_src (
      .i_core_clk (i_core_clk),
      .i_rst_n (i_rst_n),
      .i_comparator (i_comparator),
      .i_ext_osc (i_ext_osc),
      .src (src_bus.src)
   );

   function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
      sfr_hit = (addr == target);
   endfunction : sfr_hit

   assign wr_ctrl = i_sfr_wr & sfr_hit(i_sfr_addr, tmc_pkg::ADDR_CONTROL);
   assign wr_cnt_low = i_sfr_wr & sfr_hit(i_sfr_addr, tmc_pkg::ADDR_COUNT_LOW);
   assign wr_cnt_high = i_sfr_wr & sfr_hit(i_sfr_addr, tmc_pkg::ADDR_COUNT_HIGH);

   assign split_select = timer3_control[tmc_pkg::BIT_SPLIT];
   assign run_control = timer3_control[tmc_pkg::BIT_RUN];
   // one source selection feeds both bytes
   assign src_bus.src_sel = tmc_pkg::tmc_src_t'(timer3_control[tmc_pkg::BIT_SRC_MSB:tmc_pkg::BIT_SRC_LSB]);
   assign tick_low = i_low_byte_clock_select | src_bus.ext_tick;
   assign tick_high = i_high_byte_clock_select | src_bus.ext_tick;
   assign capture_event = timer3_control[tmc_pkg::BIT_CAPTURE_EN] & src_bus.cap_tick;

   // counter next state; 16-bit mode is clocked by the low byte select
   always_comb begin
      next_count_low = count_low_byte;
      next_count_high = count_high_byte;
      high_ovf_set = 1'b0;
      low_ovf_set = 1'b0;
      if (!split_select) begin
         if (run_control && tick_low) begin
            if ({count_high_byte, count_low_byte} == {tmc_pkg::BYTE_MAX, tmc_pkg::BYTE_MAX}) begin
               next_count_low = reload_low_byte;
               next_count_high = reload_high_byte;
               high_ovf_set = 1'b1;
               low_ovf_set = 1'b1;
            end else if (count_low_byte == tmc_pkg::BYTE_MAX) begin
               next_count_low = tmc_pkg::BYTE_RESET;
               next_count_high = count_high_byte + 8'h01;
               low_ovf_set = 1'b1;
            end else begin
               next_count_low = count_low_byte + 8'h01;
            end
         end
      end else begin
         if (tick_low) begin
            if (count_low_byte == tmc_pkg::BYTE_MAX) begin
               next_count_low = reload_low_byte;
               low_ovf_set = 1'b1;
            end else begin
               next_count_low = count_low_byte + 8'h01;
            end
         end
         if (run_control && tick_high) begin
            if (count_high_byte == tmc_pkg::BYTE_MAX) begin
               next_count_high = reload_high_byte;
               high_ovf_set = 1'b1;
            end else begin
               next_count_high = count_high_byte + 8'h01;
            end
         end
      end
      if (capture_event) begin
         high_ovf_set = 1'b1;
      end
   end

   // control register; a hardware set wins over a software clear
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         timer3_control <= tmc_pkg::CONTROL_RESET;
      end else begin
         if (wr_ctrl) begin
            timer3_control <= i_sfr_wdata;
         end
         if (high_ovf_set) begin
            timer3_control[tmc_pkg::BIT_HIGH_OVF] <= 1'b1;
         end
         if (low_ovf_set) begin
            timer3_control[tmc_pkg::BIT_LOW_OVF] <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         count_low_byte <= tmc_pkg::BYTE_RESET;
         count_high_byte <= tmc_pkg::BYTE_RESET;
      end else begin
         count_low_byte <= wr_cnt_low ? i_sfr_wdata : next_count_low;
         count_high_byte <= wr_cnt_high ? i_sfr_wdata : next_count_high;
      end
   end

   // capture overrides a software write to the reload bytes in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         reload_low_byte <= tmc_pkg::BYTE_RESET;
         reload_high_byte <= tmc_pkg::BYTE_RESET;
      end else if (capture_event) begin
         reload_low_byte <= count_low_byte;
         reload_high_byte <= count_high_byte;
      end else if (i_sfr_wr) begin
         if (sfr_hit(i_sfr_addr, tmc_pkg::ADDR_RELOAD_LOW)) begin
            reload_low_byte <= i_sfr_wdata;
         end
         if (sfr_hit(i_sfr_addr, tmc_pkg::ADDR_RELOAD_HIGH)) begin
            reload_high_byte <= i_sfr_wdata;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         case (i_sfr_addr)
            tmc_pkg::ADDR_CONTROL: o_sfr_rdata <= timer3_control;
            tmc_pkg::ADDR_RELOAD_LOW: o_sfr_rdata <= reload_low_byte;
            tmc_pkg::ADDR_RELOAD_HIGH: o_sfr_rdata <= reload_high_byte;
            tmc_pkg::ADDR_COUNT_LOW: o_sfr_rdata <= count_low_byte;
            tmc_pkg::ADDR_COUNT_HIGH: o_sfr_rdata <= count_high_byte;
            default: o_sfr_rdata <= 8'h00;
         endcase
      end
   end

   assign o_timer_irq = i_timer_irq_enable & (timer3_control[tmc_pkg::BIT_HIGH_OVF] |
      (timer3_control[tmc_pkg::BIT_LOW_OVF] & timer3_control[tmc_pkg::BIT_LOW_IRQ_EN]));

   a_wrap_sets_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (!split_select && run_control && tick_low && count_low_byte == 8'hff && count_high_byte == 8'hff)
      |=> timer3_control[7])
      else $error("16-bit wrap did not set high flag");

   a_wrap_reloads: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (!split_select && run_control && tick_low && {count_high_byte, count_low_byte} == 16'hffff
      && !wr_cnt_low && !wr_cnt_high)
      |=> {count_high_byte, count_low_byte} == $past({reload_high_byte, reload_low_byte}))
      else $error("16-bit wrap did not load reload value");

   a_high_flag_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (timer3_control[7] && !wr_ctrl) |=> timer3_control[7])
      else $error("high flag cleared without software write");

   a_low_wrap_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tick_low && count_low_byte == 8'hff && (split_select || run_control)) |=> timer3_control[6])
      else $error("low byte wrap did not set low flag");

   a_irq_low_byte: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (low_ovf_set && timer3_control[5] && !wr_ctrl && i_timer_irq_enable) |=> (o_timer_irq || !i_timer_irq_enable))
      else $error("low byte overflow gave no interrupt");

   a_irq_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(timer3_control[7]) && i_timer_irq_enable |-> o_timer_irq)
      else $error("high flag gave no interrupt");

   a_halt_when_stopped: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (!split_select && !run_control && !wr_cnt_low && !wr_cnt_high)
      |=> (count_low_byte == $past(count_low_byte) && count_high_byte == $past(count_high_byte)))
      else $error("stopped 16-bit timer changed");

   a_split_low_runs: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (split_select && i_low_byte_clock_select && !wr_cnt_low && count_low_byte != 8'hff)
      |=> count_low_byte == $past(count_low_byte) + 8'h01)
      else $error("split low byte did not count");

   a_capture_copy: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      capture_event |=> (reload_low_byte == $past(count_low_byte)
      && reload_high_byte == $past(count_high_byte) && timer3_control[7]))
      else $error("capture did not copy count");

   a_reset_clears: assert property (@(posedge i_core_clk)
      !i_rst_n |=> timer3_control == 8'h00)
      else $error("reset left control bits set");
endmodule : tmc_timer3

// file: testbench/tmc_timer3_tb.sv
// self-checking bench for the timer 3 control block: sfr access, counting, reload, capture, flags
// assumes the design top drives o_sfr_rdata one edge after a read strobe and flags show the cycle after
`timescale 1ns/1ps
module tmc_timer3_tb;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tmc_row_t;
   logic clk, rst_n, sfr_wr, sfr_rd, hsel, lsel, irq_en, cmp, osc, irq;
   logic [7:0] sfr_addr, sfr_wdata, rdata, v;
   int n_mismatch, cmp_count;
   tmc_row_t rows[7] = '{'{8'h92, 8'ha5, 8'ha5}, '{8'h93, 8'h5a, 8'h5a}, '{8'h94, 8'h3c, 8'h3c},
      '{8'h95, 8'hc3, 8'hc3}, '{8'h91, 8'h3b, 8'h3b}, '{8'h90, 8'hff, 8'h00}, '{8'ha0, 8'h77, 8'h00}};

   tmc_timer3 i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
      .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata), .i_high_byte_clock_select(hsel),
      .i_low_byte_clock_select(lsel), .i_timer_irq_enable(irq_en), .i_comparator(cmp), .i_ext_osc(osc),
      .o_timer_irq(irq));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi, input string msg);
      cmp_count++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h outside %h..%h", $time, msg, got, lo, hi);
      end
   endtask : chk_rng

   task automatic chk_irq(input logic exp, input string msg);
      #1;
      cmp_count++;
      if (irq !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s irq %b expected %b", $time, msg, irq, exp);
      end
   endtask : chk_irq

   // core-clock ticks on the chosen bytes for n cycles, then frozen again
   task automatic run_core(input logic h, input logic l, input int n);
      @(posedge clk);
      hsel <= h;
      lsel <= l;
      cyc(n);
      hsel <= 1'b0;
      lsel <= 1'b0;
   endtask : run_core

   // slow pulses well under core/2 so the synchronisers see every edge
   task automatic pulse(input logic use_osc, input int n);
      repeat (n) begin
         @(posedge clk);
         if (use_osc) osc <= 1'b1; else cmp <= 1'b1;
         cyc(4);
         if (use_osc) osc <= 1'b0; else cmp <= 1'b0;
         cyc(3);
      end
   endtask : pulse

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      cyc(20000);
      n_mismatch++;
      $display("mismatch at %0t: run limit reached", $time);
      wrap_up();
   end

   initial begin
      rst_n = 1'b0; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
      hsel = 1'b0; lsel = 1'b0; irq_en = 1'b1; cmp = 1'b0; osc = 1'b0;
      cyc(20);
      rst_n <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         rd(8'h91 + 8'(a), v);
         chk(v, 8'h00, "reset value");
      end
      chk_irq(1'b0, "irq after reset");
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk(v, rows[i].e, "register row");
      end
      $display("test register rows done");
      // src 01 with the run bit clear holds the 16-bit count while the low byte select ticks
      wr(8'h91, 8'h01);
      wr(8'h94, 8'h10);
      run_core(1'b0, 1'b1, 10);
      rd(8'h94, v);
      chk(v, 8'h10, "stopped count moved");
      wr(8'h92, 8'h00); wr(8'h93, 8'h34); wr(8'h95, 8'hff); wr(8'h94, 8'hfe); wr(8'h91, 8'h05);
      run_core(1'b0, 1'b1, 4);
      rd(8'h91, v);
      chk(v, 8'hc5, "flags after full wrap");
      chk_irq(1'b1, "irq on high flag");
      rd(8'h95, v);
      chk(v, 8'h34, "reload high after wrap");
      @(posedge clk);
      irq_en <= 1'b0;
      chk_irq(1'b0, "irq with timer irq disabled");
      cyc(1);
      irq_en <= 1'b1;
      cyc(19);
      rd(8'h91, v);
      chk(v, 8'hc5, "flags still set");
      wr(8'h91, 8'h65);
      chk_irq(1'b1, "irq on low flag with enable");
      wr(8'h91, 8'h45);
      chk_irq(1'b0, "low flag without enable");
      $display("test 16-bit wrap done");
      wr(8'h91, 8'h29); wr(8'h95, 8'h10); wr(8'h94, 8'hfe); wr(8'h92, 8'h80);
      run_core(1'b1, 1'b1, 5);
      rd(8'h95, v);
      chk(v, 8'h10, "high byte gated by run");
      rd(8'h94, v);
      chk_rng(v, 8'h80, 8'h84, "low byte reload");
      rd(8'h91, v);
      chk(v, 8'h69, "split low flag only");
      chk_irq(1'b1, "irq on split low overflow");
      wr(8'h91, 8'h0d); wr(8'h93, 8'h22); wr(8'h95, 8'hff);
      run_core(1'b1, 1'b0, 3);
      rd(8'h91, v);
      chk(v, 8'h8d, "split high flag");
      rd(8'h95, v);
      chk_rng(v, 8'h22, 8'h24, "high byte reload");
      wr(8'h94, 8'h00); wr(8'h95, 8'h00);
      pulse(1'b1, 8);
      cyc(6);
      rd(8'h94, v);
      chk(v, 8'h01, "split low on osc/8");
      rd(8'h95, v);
      chk(v, 8'h01, "split high on osc/8");
      $display("test split done");
      for (int c = 0; c < 2; c++) begin
         wr(8'h95, 8'h00);
         wr(8'h94, 8'h00);
         wr(8'h91, c ? 8'h06 : 8'h04);
         cyc(120);
         wr(8'h91, 8'h05);
         rd(8'h94, v);
         chk_rng(v, 8'd9, 8'd11, "core/12 count");
      end
      wr(8'h94, 8'h00); wr(8'h91, 8'h07);
      pulse(1'b0, 5);
      cyc(6);
      wr(8'h91, 8'h05);
      rd(8'h94, v);
      chk(v, 8'h05, "comparator clock count");
      wr(8'h94, 8'h00);
      pulse(1'b1, 16);
      cyc(6);
      rd(8'h94, v);
      chk(v, 8'h02, "osc/8 clock count");
      $display("test source select done");
      for (int c = 0; c < 2; c++) begin
         wr(8'h92, 8'h00); wr(8'h93, 8'h00); wr(8'h95, 8'h00); wr(8'h94, 8'h00);
         wr(8'h91, c ? 8'h15 : 8'h14);
         @(posedge clk);
         lsel <= 1'b1;
         pulse(c[0], c ? 8 : 1);
         cyc(6);
         lsel <= 1'b0;
         rd(8'h91, v);
         chk(v & 8'h80, 8'h80, "capture flag");
         rd(8'h92, v);
         chk_rng(v, c ? 8'h28 : 8'h01, c ? 8'h5a : 8'h10, "captured low");
         rd(8'h93, v);
         chk(v, 8'h00, "captured high");
      end
      $display("test capture done");
      wr(8'h91, 8'hed);
      chk_irq(1'b1, "irq from flags set by software");
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      chk_irq(1'b0, "irq after mid-run reset");
      rd(8'h91, v);
      chk(v, 8'h00, "control after mid-run reset");
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule : tmc_timer3_tb
